// ===== hdl/epx_core.sv
// preset, position, speed and acceleration exchange of the shaft encoder
// Contract
// R1 - preset sets offset; position reports preset
// R2 - preset applies on scaled position steps
// R3 - 32-bit: bit 31 controls, bits 30:0 value
// R4 - 16-bit: bit 15 controls, bits 14:0 value
// R5 - 64-bit: bit 63 controls, low bits value
// R6 - master clears control after echo seen
// R7 - last received preset kept as default
// R8 - offset readable, restored after restart
// R9 - master presets only at standstill
// R10 - master sends scaling before any preset
// R11 - D1h/F1h: 32-bit position, 32-bit preset
// R12 - D0h/F0h: 16-bit position, 16-bit preset
// R13 - D3h/F3h: position, speed, acceleration words
// R14 - master enables class 2 before D3h/F3h
// R15 - position sent most significant octet first
// R16 - speed scaled by 2^14/60000 and T; code scales the step per sample period by 2^14/2^RES_BITS only
// R17 - speed two's complement, sign is direction
// R18 - speed is mean of last eight samples
// R19 - acceleration sums five-sample speed differences
// R20 - sampling every 1 ms or 10 ms
// R21 - capture once per new preset value
//
// Register access over AHB-Lite and the address map are this design's own decisions.
`timescale 1ns/100ps
module epx_core
   import epx_pkg::*;
#(
   parameter int RES_BITS = 12,
   parameter int SAMPLE_CYC = SAMPLE_BASE_CYC
) (
   // clock, reset, enable
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // scaled position and stored offset
   input wire logic [POS_W-1:0] pos_raw,
   input wire logic [POS_W-1:0] nv_offset,
   // cyclic input data and offset store
   output logic [2*WORD_W-1:0] in_data,
   output logic [POS_W-1:0] offset_out,
   output logic offset_store
);

   epx_fmt_e fmt;
   logic out_en, ctl, capture, tick, take;
   logic [POS_W-1:0] pval;
   logic [CFG_W-1:0] cfg_q;
   logic [WORD_W-1:0] out_lo_q, out_hi_q;
   logic [POS_W-1:0] offset_q, pos_q, pos_raw_q, preset_def_q, pval_seen_q;
   logic restored_q, ctl_seen_q, primed_q, tick1_q, tick2_q, store_q;
   logic [31:0] cnt_q, limit;
   logic wr_pend_q;
   logic [ADDR_W-1:0] waddr_q;
   logic [31:0] hrdata_q, rd_val;
   logic [2*WORD_W-1:0] in_q, in_next;
   logic signed [POS_W-1:0] diff;
   logic signed [POS_W+SPEED_Q_BITS-1:0] spd_ext, spd_wide;
   logic [SPD_W-1:0] spd_raw, speed_q, accel_q, avg;
   logic [AVG_DEPTH-1:0][SPD_W-1:0] hist_q;
   logic [ACC_DEPTH-1:0][SPD_W-1:0] acc_h_q;
   logic signed [SPD_W+AVG_SHIFT-1:0] avg_sum;
   logic signed [SPD_W+ACC_GROW-1:0] acc_sum;

   // R11 R12 R13 format from configuration code
   always_comb begin
      unique case (cfg_q[CFG_CODE_LSB +: CFG_CODE_W])
         CFG_C1_16, CFG_C2_16: fmt = EPX_FMT_16;
         CFG_C1_64, CFG_C2_64: fmt = EPX_FMT_64;
         default: fmt = EPX_FMT_32;
      endcase
   end

   // R11 R12 R13 output words only in F codes
   assign out_en = (cfg_q[CFG_CODE_LSB +: CFG_CODE_W] == CFG_C2_16) ||
                   (cfg_q[CFG_CODE_LSB +: CFG_CODE_W] == CFG_C2_32) ||
                   (cfg_q[CFG_CODE_LSB +: CFG_CODE_W] == CFG_C2_64);

   // R3 R4 R5 control bit and preset value
   always_comb begin
      unique case (fmt)
         EPX_FMT_16: begin
            ctl = out_lo_q[CTL16_BIT];
            pval = POS_W'(out_lo_q[PV16_W-1:0]);
         end
         EPX_FMT_64: begin
            ctl = out_hi_q[CTL64_HI_BIT];
            pval = out_lo_q;
         end
         default: begin
            ctl = out_lo_q[CTL32_BIT];
            pval = POS_W'(out_lo_q[PV32_W-1:0]);
         end
      endcase
   end

   // R21 capture on first sight or changed value
   assign capture = ce && restored_q && out_en && ctl &&
                    (!ctl_seen_q || (pval != pval_seen_q));

   // R20 sample period 1 ms or 10 ms
   assign limit = cfg_q[CFG_SAMP_BIT] ? 32'(SAMPLE_CYC * SAMPLE_SLOW_MUL)
                                      : 32'(SAMPLE_CYC);
   assign tick = ce && (cnt_q >= limit - 32'h1);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q <= 32'h0;
      end else if (ce) begin
         cnt_q <= tick ? 32'h0 : cnt_q + 32'h1;
      end
   end

   // ahb-lite address phase
   assign take = ce && hsel && hready && htrans[HTRANS_ACT_BIT];
   assign hreadyout = ce;
   assign hresp = HRESP_OKAY;
   assign hrdata = hrdata_q;

   always_comb begin
      unique case (haddr[ADDR_W-1:0])
         A_CFG: rd_val = 32'(cfg_q);
         A_OUT_LO: rd_val = out_lo_q;
         A_OUT_HI: rd_val = out_hi_q;
         A_IN_LO: rd_val = in_q[WORD_W-1:0];
         A_IN_HI: rd_val = in_q[2*WORD_W-1:WORD_W];
         // R8 offset readable
         A_OFFSET: rd_val = offset_q;
         A_PRESET: rd_val = preset_def_q;
         A_STATUS: rd_val = 32'({ctl_seen_q, restored_q,
                                 ctl && (pos_q == preset_def_q)});
         default: rd_val = 32'h0;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         waddr_q <= '0;
         hrdata_q <= 32'h0;
      end else if (ce) begin
         wr_pend_q <= take && hwrite;
         if (take) begin
            waddr_q <= haddr[ADDR_W-1:0];
         end
         if (take && !hwrite) begin
            hrdata_q <= rd_val;
         end
      end
   end

   // ahb-lite data phase writes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_q <= CFG_RST;
         out_lo_q <= 32'h0;
         out_hi_q <= 32'h0;
      end else if (ce && wr_pend_q) begin
         unique case (waddr_q)
            A_CFG: cfg_q <= hwdata[CFG_W-1:0];
            A_OUT_LO: out_lo_q <= hwdata;
            A_OUT_HI: out_hi_q <= hwdata;
            default: ;
         endcase
      end
   end

   // R1 R2 R7 R8 preset, offset and reported position
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         restored_q <= 1'b0;
         offset_q <= '0;
         pos_q <= '0;
         preset_def_q <= '0;
         pval_seen_q <= '0;
         ctl_seen_q <= 1'b0;
         store_q <= 1'b0;
      end else if (ce) begin
         store_q <= capture;
         if (!restored_q) begin
            restored_q <= 1'b1;
            offset_q <= nv_offset;
         end else if (capture) begin
            offset_q <= pval - pos_raw_q;
            pos_q <= pval;
            preset_def_q <= pval;
            pval_seen_q <= pval;
            ctl_seen_q <= 1'b1;
         end else begin
            if (!ctl) begin
               ctl_seen_q <= 1'b0;
            end
            if (tick) begin
               pos_q <= pos_raw + offset_q;
            end
         end
      end
   end

   assign offset_out = offset_q;
   assign offset_store = store_q;

   // R16 R17 signed step per period to 2^14 units
   assign diff = $signed(pos_raw - pos_raw_q);
   assign spd_ext = $signed({{SPEED_Q_BITS{diff[POS_W-1]}}, diff});
   assign spd_wide = (spd_ext <<< SPEED_Q_BITS) >>> RES_BITS;
   assign spd_raw = spd_wide[SPD_W-1:0];

   // R18 mean of last eight samples
   always_comb begin
      avg_sum = '0;
      for (int i = 0; i < AVG_DEPTH; i++) begin
         avg_sum = avg_sum +
            $signed({{AVG_SHIFT{hist_q[i][SPD_W-1]}}, hist_q[i]});
      end
   end
   assign avg = SPD_W'(avg_sum >>> AVG_SHIFT);

   // R19 sum of differences of five speeds
   always_comb begin
      acc_sum = '0;
      for (int i = 0; i < ACC_DEPTH - 1; i++) begin
         acc_sum = acc_sum +
            $signed({{ACC_GROW{acc_h_q[i][SPD_W-1]}}, acc_h_q[i]}) -
            $signed({{ACC_GROW{acc_h_q[i+1][SPD_W-1]}}, acc_h_q[i+1]});
      end
   end

   // R20 sampling pipeline
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pos_raw_q <= '0;
         primed_q <= 1'b0;
         tick1_q <= 1'b0;
         tick2_q <= 1'b0;
         hist_q <= '0;
         acc_h_q <= '0;
         speed_q <= '0;
         accel_q <= '0;
      end else if (ce) begin
         tick1_q <= tick;
         tick2_q <= tick1_q;
         if (tick) begin
            pos_raw_q <= pos_raw;
            primed_q <= 1'b1;
            if (primed_q) begin
               hist_q <= {hist_q[AVG_DEPTH-2:0], spd_raw};
            end
         end
         if (tick1_q) begin
            speed_q <= avg;
            acc_h_q <= {acc_h_q[ACC_DEPTH-2:0], avg};
         end
         if (tick2_q) begin
            accel_q <= SPD_W'(acc_sum);
         end
      end
   end

   // R13 R15 cyclic input words, msb octet first
   always_comb begin
      unique case (fmt)
         EPX_FMT_16: in_next = (2*WORD_W)'(pos_q[SPD_W-1:0]);
         EPX_FMT_64: in_next = {pos_q, speed_q, accel_q};
         default: in_next = (2*WORD_W)'(pos_q);
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         in_q <= '0;
      end else if (ce) begin
         in_q <= in_next;
      end
   end

   assign in_data = in_q;

   preset_offset_a: // R1
   assert property (@(posedge hclk) disable iff (!hresetn)
      capture |=> (offset_q == $past(pval) - $past(pos_raw_q)) &&
                  (pos_q == $past(pval)))
      else $error("offset not derived from preset");

   ctl32_a: // R3
   assert property (@(posedge hclk) disable iff (!hresetn)
      (capture && fmt == EPX_FMT_32) |->
         out_lo_q[CTL32_BIT] && pval[POS_W-1] == 1'b0)
      else $error("32-bit preset taken without bit 31");

   ctl16_a: // R4
   assert property (@(posedge hclk) disable iff (!hresetn)
      (capture && fmt == EPX_FMT_16) |->
         out_lo_q[CTL16_BIT] && pval[POS_W-1:PV16_W] == '0)
      else $error("16-bit preset taken without bit 15");

   ctl64_a: // R5
   assert property (@(posedge hclk) disable iff (!hresetn)
      (capture && fmt == EPX_FMT_64) |-> out_hi_q[CTL64_HI_BIT])
      else $error("64-bit preset taken without bit 63");

   preset_default_a: // R7
   assert property (@(posedge hclk) disable iff (!hresetn)
      capture |=> ##1 (preset_def_q == $past(pval, 2)) || !ce)
      else $error("default preset not kept");

   offset_restore_a: // R8
   assert property (@(posedge hclk) disable iff (!hresetn)
      (ce && !restored_q) |=> restored_q && offset_q == $past(nv_offset))
      else $error("offset not restored after reset");

   msb_first_a: // R15
   assert property (@(posedge hclk) disable iff (!hresetn)
      (ce && fmt == EPX_FMT_32 && $stable(fmt)) |=>
         in_data[WORD_W-1:WORD_W-8] == $past(pos_q[POS_W-1:POS_W-8]))
      else $error("position octet order wrong");

   speed_avg_a: // R18
   assert property (@(posedge hclk) disable iff (!hresetn)
      (ce && tick1_q) |=> speed_q == $past(avg))
      else $error("speed is not the eight-sample mean");

   accel_sum_a: // R19
   assert property (@(posedge hclk) disable iff (!hresetn)
      (ce && tick2_q) |=> accel_q == $past(SPD_W'(acc_sum)))
      else $error("acceleration not the summed differences");

   sample_gap_a: // R20
   assert property (@(posedge hclk) disable iff (!hresetn)
      (ce && cnt_q < limit - 32'h1) |-> !tick)
      else $error("sample taken before period ends");

   capture_once_a: // R21
   assert property (@(posedge hclk) disable iff (!hresetn)
      capture |=> !(capture && $stable(pval)))
      else $error("preset captured twice for one value");

endmodule : epx_core

// ===== common/epx_pkg.sv
// constants, register map and types of the encoder preset/speed exchange
package epx_pkg;
   // data widths
   localparam int POS_W = 32;
   localparam int SPD_W = 16;
   localparam int WORD_W = 32;
   localparam int ADDR_W = 8;
   // configuration codes
   localparam logic [7:0] CFG_C1_16 = 8'hd0;
   localparam logic [7:0] CFG_C1_32 = 8'hd1;
   localparam logic [7:0] CFG_C1_64 = 8'hd3;
   localparam logic [7:0] CFG_C2_16 = 8'hf0;
   localparam logic [7:0] CFG_C2_32 = 8'hf1;
   localparam logic [7:0] CFG_C2_64 = 8'hf3;
   // preset control and value positions
   localparam int CTL16_BIT = 15;
   localparam int CTL32_BIT = 31;
   localparam int CTL64_HI_BIT = 31;
   localparam int PV16_W = 15;
   localparam int PV32_W = 31;
   // configuration register fields
   localparam int CFG_CODE_LSB = 0;
   localparam int CFG_CODE_W = 8;
   localparam int CFG_SAMP_BIT = 8;
   localparam int CFG_CLASS2_BIT = 9;
   localparam int CFG_W = 10;
   localparam logic [CFG_W-1:0] CFG_RST = 10'h2f1;
   // status register bits
   localparam int STAT_ECHO_BIT = 0;
   localparam int STAT_RESTORED_BIT = 1;
   localparam int STAT_HELD_BIT = 2;
   // register byte addresses
   localparam logic [ADDR_W-1:0] A_CFG = 8'h00;
   localparam logic [ADDR_W-1:0] A_OUT_LO = 8'h04;
   localparam logic [ADDR_W-1:0] A_OUT_HI = 8'h08;
   localparam logic [ADDR_W-1:0] A_IN_LO = 8'h0c;
   localparam logic [ADDR_W-1:0] A_IN_HI = 8'h10;
   localparam logic [ADDR_W-1:0] A_OFFSET = 8'h14;
   localparam logic [ADDR_W-1:0] A_PRESET = 8'h18;
   localparam logic [ADDR_W-1:0] A_STATUS = 8'h1c;
   // sampling timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int SAMPLE_BASE_NS = 1_000_000;
   localparam int SAMPLE_SLOW_MUL = 10;
   localparam int SAMPLE_BASE_CYC = SAMPLE_BASE_NS / CLK_PERIOD_NS;
   // speed and acceleration arithmetic
   localparam int SPEED_Q_BITS = 14;
   localparam int AVG_DEPTH = 8;
   localparam int AVG_SHIFT = 3;
   localparam int ACC_DEPTH = 5;
   localparam int ACC_GROW = 3;
   // bus encodings
   localparam int HTRANS_ACT_BIT = 1;
   localparam logic HRESP_OKAY = 1'b0;
   // cyclic data format
   typedef enum logic [1:0] {EPX_FMT_16, EPX_FMT_32, EPX_FMT_64} epx_fmt_e;
endpackage : epx_pkg

// ===== verif/epx_pos_src.sv
// scaled position source and nonvolatile offset store
`timescale 1ns/100ps
module epx_pos_src
   import epx_pkg::*;
#(
   parameter logic [POS_W-1:0] NV_INIT = 32'h0000_0100
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // shaft motion per clock
   input wire logic signed [15:0] vel,
   // core side
   input wire logic [POS_W-1:0] offset_out,
   input wire logic offset_store,
   output logic [POS_W-1:0] pos_raw,
   output logic [POS_W-1:0] nv_offset
);
   logic [POS_W-1:0] nv_q = NV_INIT;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pos_raw <= 32'h0000_4000;
      end else begin
         pos_raw <= pos_raw + {{16{vel[15]}}, vel};
      end
   end
   always @(posedge hclk) begin
      if (offset_store === 1'b1) begin
         nv_q <= offset_out;
      end
   end
   assign nv_offset = nv_q;
endmodule : epx_pos_src

// ===== verif/encoder_preset_speed_exchange_bench.sv
// self-checking bench of the exchange core
`timescale 1ns/100ps
module encoder_preset_speed_exchange_bench import epx_pkg::*;;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic ce = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic signed [15:0] vel = 16'sh0;
   logic hreadyout, hresp, offset_store;
   logic [31:0] hrdata, pos_raw, nv_offset, offset_out, rdv, last_off;
   logic [63:0] in_data;
   int n_fail = 0;
   int checks = 0;
   int cyc = 0;
   int n_store = 0;
   always #5 hclk = ~hclk;
   epx_core #(.SAMPLE_CYC(20)) i_dut (
      .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .pos_raw(pos_raw),
      .nv_offset(nv_offset), .in_data(in_data),
      .offset_out(offset_out), .offset_store(offset_store));
   epx_pos_src i_src (
      .hclk(hclk), .hresetn(hresetn), .vel(vel),
      .offset_out(offset_out), .offset_store(offset_store),
      .pos_raw(pos_raw), .nv_offset(nv_offset));
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : tally_and_finish
   always @(posedge hclk) begin
      cyc++;
      if (offset_store === 1'b1) n_store++;
      if (cyc == 20000) begin
         n_fail++;
         tally_and_finish;
      end
   end
   task automatic chk(input logic [63:0] got, exp, input string m);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask : chk
   task automatic wt(input int n);
      repeat (n) @(posedge hclk);
   endtask : wt
   task automatic bus(input logic [7:0] a, input logic w,
      input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rdv = hrdata;
      hsel <= 1'b0;
   endtask : bus
   task automatic rchk(input logic [7:0] a, input logic [31:0] e,
      input string m);
      bus(a, 1'b0, 32'h0);
      chk(rdv, e, m);
   endtask : rchk
   task automatic t_restore;
      rchk(A_CFG, 32'h0000_02f1, "cfg reset");
      chk(hresp, HRESP_OKAY, "okay response");
      rchk(A_OFFSET, last_off, "offset restore");
      rchk(A_STATUS, 32'h0000_0002, "restored flag");
      rchk(8'h40, 32'h0, "unmapped read");
      $display("done restore");
   endtask : t_restore
   task automatic t_preset32;
      logic [31:0] p;
      int n0;
      vel <= 16'sh0;
      wt(30);
      p = pos_raw;
      n0 = n_store;
      bus(A_OUT_LO, 1'b1, 32'h8123_4567);
      wt(8);
      chk(in_data[31:0], 32'h0123_4567, "pos32 preset");
      chk(in_data[31:24], 8'h01, "top octet");
      last_off = 32'h0123_4567 - p;
      rchk(A_OFFSET, last_off, "offset32");
      rchk(A_PRESET, 32'h0123_4567, "default32");
      bus(A_STATUS, 1'b0, 32'h0);
      chk({rdv[2], rdv[0]}, 2'b11, "echo");
      wt(60);
      chk(n_store - n0, 1, "one capture");
      bus(A_OUT_LO, 1'b1, 32'h0000_0055);
      wt(30);
      chk(in_data[31:0], 32'h0123_4567, "no preset");
      $display("done preset32");
   endtask : t_preset32
   task automatic t_preset16;
      bus(A_OUT_LO, 1'b1, 32'h0);
      bus(A_CFG, 1'b1, 32'h0000_02d0);
      bus(A_OUT_LO, 1'b1, 32'h0000_8055);
      wt(30);
      chk(in_data[15:0], 16'h4567, "d0 refuses");
      bus(A_OUT_LO, 1'b1, 32'h0);
      bus(A_CFG, 1'b1, 32'h0000_02f0);
      bus(A_OUT_LO, 1'b1, 32'h0000_8055);
      wt(30);
      chk(in_data[15:0], 16'h0055, "pos16 preset");
      bus(A_OUT_LO, 1'b1, 32'h0);
      bus(A_CFG, 1'b1, 32'h0000_02d1);
      bus(A_OUT_LO, 1'b1, 32'h8000_0099);
      wt(30);
      chk(in_data[31:0], 32'h0055, "d1 refuses");
      bus(A_OUT_LO, 1'b1, 32'h0);
      $display("done preset16");
   endtask : t_preset16
   task automatic t_preset64;
      // class 2 enabled with the code
      bus(A_CFG, 1'b1, 32'h0000_02d3);
      bus(A_OUT_HI, 1'b1, 32'h8000_0000);
      bus(A_OUT_LO, 1'b1, 32'h0000_0777);
      wt(30);
      chk(in_data[63:32], 32'h0055, "d3 refuses");
      bus(A_OUT_HI, 1'b1, 32'h0);
      bus(A_CFG, 1'b1, 32'h0000_02f3);
      wt(30);
      chk(in_data[63:32], 32'h0055, "hi clear");
      bus(A_OUT_HI, 1'b1, 32'h8000_0000);
      wt(30);
      chk(in_data[63:32], 32'h0777, "pos64 preset");
      last_off = 32'h0000_0777 - pos_raw;
      chk(offset_out, last_off, "offset port");
      rchk(A_OFFSET, last_off, "offset64");
      rchk(A_PRESET, 32'h0777, "default64");
      bus(A_OUT_HI, 1'b1, 32'h0);
      $display("done preset64");
   endtask : t_preset64
   task automatic t_freeze;
      logic [63:0] d;
      ce <= 1'b0;
      vel <= 16'sd1;
      wt(1);
      d = in_data;
      wt(50);
      chk(in_data, d, "frozen data");
      chk(hreadyout, 1'b0, "frozen stall");
      ce <= 1'b1;
      vel <= 16'sh0;
      $display("done freeze");
   endtask : t_freeze
   task automatic t_speed(input logic [31:0] cfg,
      input logic signed [15:0] v, input logic [15:0] e, input int per);
      bus(A_CFG, 1'b1, cfg);
      vel <= v;
      wt(16 * per);
      chk(in_data[31:16], e, "speed");
      chk(in_data[15:0], 16'h0, "accel steady");
      vel <= 16'sh0;
      wt(16 * per);
      chk(in_data[31:16], 16'h0, "speed stop");
      $display("done speed");
   endtask : t_speed
   task automatic t_restart;
      hresetn <= 1'b0;
      wt(3);
      hresetn <= 1'b1;
      wt(2);
      t_restore();
   endtask : t_restart
   initial begin
      last_off = 32'h0000_0100;
      wt(16);
      hresetn <= 1'b1;
      t_restore();
      t_preset32();
      t_preset16();
      t_preset64();
      t_freeze();
      t_speed(32'h0000_02f3, 16'sd1, 16'h0050, 20);
      t_speed(32'h0000_02f3, -16'sd1, 16'hffb0, 20);
      t_speed(32'h0000_03f3, 16'sd1, 16'h0320, 200);
      t_restart();
      tally_and_finish();
   end
endmodule : encoder_preset_speed_exchange_bench
